//--- core/lbm_top.v
/*
 * Local bus side of a backplane controller facing a 16-bit processor:
 * address subset and strobe in both directions, bus mastership request
 * and grant, bus error and relinquish-and-retry signalling.
 * Assumes all inputs synchronous to clk; the pad logic resolves each
 * two-way pin from its output and active-low output enable.
 */
`timescale 1ns/1ns
`include "lbm_regs.vh"

// Summary of operation
// - seven two-way address lines, drive or sample
// - strobe low only after address valid
// - error code in acknowledge raises bus error
// - collision drives bus error and stop together
// - incoming backplane transaction beats local transfer
// - wait for grant sampled low first
// - push-pull request low from requester until grant taken
// - grant acknowledge low once mastership taken
// - stop held until null cycle; error after strobe
module lbm_top (
  input wire clk,
  input wire sys_rst,
  // local bus address pins
  input wire [`LBM_UPPER_W-1:0] upper_local_address_in,
  input wire [`LBM_LOWER_W-1:0] lower_local_address_in,
  output reg [`LBM_UPPER_W-1:0] upper_local_address_out_r,
  output reg [`LBM_LOWER_W-1:0] lower_local_address_out_r,
  output reg local_address_oe_n_r,
  input wire local_address_strobe_in_n,
  output reg local_address_strobe_out_n_r,
  output reg local_address_strobe_oe_n_r,
  // mastership
  output reg bus_request_out_n_r,
  input wire bus_grant_in_n,
  output reg grant_acknowledge_out_n_r,
  // error signalling
  output wire bus_error_out_n_r,
  output wire processor_stop_line_n_r,
  // backplane engine side
  input wire bp_req,
  input wire [`LBM_ADDR_W-1:0] bp_addr,
  input wire bp_access_done,
  output reg bp_granted_r,
  input wire cpu_bp_access,
  input wire ack_cycle,
  input wire [`LBM_TM_W-1:0] transfer_mode_bits,
  input wire incoming_txn,
  input wire attention_null_cycle,
  // processor register access seen by the block
  output reg [`LBM_ADDR_W-1:0] cpu_addr_r,
  output reg cpu_addr_valid_r
);

  reg [`LBM_ST_W-1:0] st_r;
  reg [`LBM_ST_W-1:0] st_nxt;
  reg [`LBM_CNT_W-1:0] cnt_r;
  reg [`LBM_CNT_W-1:0] cnt_nxt;
  reg bus_request_out_n_nxt;
  reg grant_acknowledge_out_n_nxt;
  reg local_address_oe_n_nxt;
  reg local_address_strobe_oe_n_nxt;
  reg local_address_strobe_out_n_nxt;
  reg bp_granted_nxt;
  reg [`LBM_UPPER_W-1:0] upper_local_address_out_nxt;
  reg [`LBM_LOWER_W-1:0] lower_local_address_out_nxt;
  reg cpu_addr_valid_nxt;
  reg [`LBM_ADDR_W-1:0] cpu_addr_nxt;
  wire [`LBM_ADDR_W-1:0] pin_addr;
  genvar bit_i;

  // ----------------------------------------------------------------------
  // pin address assembly, one slice per address pin
  // ----------------------------------------------------------------------
  generate
    for (bit_i = 0; bit_i < `LBM_ADDR_W; bit_i = bit_i + 1) begin : g_pin
      if (bit_i < `LBM_LOWER_W) begin : g_lower
        assign pin_addr[bit_i] = lower_local_address_in[bit_i];
      end else begin : g_upper
        assign pin_addr[bit_i] = upper_local_address_in[bit_i - `LBM_LOWER_W];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // error and retry sequencer
  // ----------------------------------------------------------------------
  lbm_err_seq u_err (
    .clk(clk),
    .sys_rst(sys_rst),
    .cpu_access(cpu_bp_access),
    .ack_cycle(ack_cycle),
    .transfer_mode_bits(transfer_mode_bits),
    .incoming_txn(incoming_txn),
    .attention_null_cycle(attention_null_cycle),
    .strobe_in_n(local_address_strobe_in_n),
    .bus_error_out_n_r(bus_error_out_n_r),
    .processor_stop_line_n_r(processor_stop_line_n_r)
  );

  // ----------------------------------------------------------------------
  // mastership state machine
  // ----------------------------------------------------------------------
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      `LBM_ST_IDLE: begin
        if (bp_req) begin
          st_nxt = `LBM_ST_REQ;
        end
      end
      `LBM_ST_REQ: begin
        // processor must also have finished its own cycle
        if (!bus_grant_in_n && local_address_strobe_in_n) begin
          st_nxt = `LBM_ST_ADDR;
          cnt_nxt = `LBM_SETUP_CYC;
        end
      end
      `LBM_ST_ADDR: begin
        if (cnt_r == `LBM_CNT_ONE) begin
          st_nxt = `LBM_ST_STRB;
        end else begin
          cnt_nxt = cnt_r - `LBM_CNT_ONE;
        end
      end
      `LBM_ST_STRB: begin
        if (bp_access_done) begin
          st_nxt = `LBM_ST_DONE;
        end
      end
      `LBM_ST_DONE: begin
        st_nxt = `LBM_ST_IDLE;
      end
      default: begin
        st_nxt = `LBM_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registered output next values, decoded from the next state
  // ----------------------------------------------------------------------
  always @* begin
    bus_request_out_n_nxt = 1'b1;
    grant_acknowledge_out_n_nxt = 1'b1;
    local_address_oe_n_nxt = 1'b1;
    local_address_strobe_oe_n_nxt = 1'b1;
    local_address_strobe_out_n_nxt = 1'b1;
    bp_granted_nxt = 1'b0;
    upper_local_address_out_nxt = upper_local_address_out_r;
    lower_local_address_out_nxt = lower_local_address_out_r;
    case (st_nxt)
      `LBM_ST_REQ: begin
        // request held until the grant is sampled low with the strobe idle
        bus_request_out_n_nxt = 1'b0;
      end
      `LBM_ST_ADDR: begin
        grant_acknowledge_out_n_nxt = 1'b0;
        // strobe enable moves with the address so the pin never floats
        local_address_oe_n_nxt = 1'b0;
        local_address_strobe_oe_n_nxt = 1'b0;
        // latched once, on the grant, so it is stable before the strobe
        if (st_r == `LBM_ST_REQ) begin
          upper_local_address_out_nxt = bp_addr[`LBM_ADDR_W-1:`LBM_LOWER_W];
          lower_local_address_out_nxt = bp_addr[`LBM_LOWER_W-1:0];
        end
      end
      `LBM_ST_STRB: begin
        grant_acknowledge_out_n_nxt = 1'b0;
        local_address_oe_n_nxt = 1'b0;
        local_address_strobe_oe_n_nxt = 1'b0;
        // strobe only after the setup count has elapsed
        local_address_strobe_out_n_nxt = 1'b0;
        bp_granted_nxt = 1'b1;
      end
      default: begin
        bus_request_out_n_nxt = 1'b1;
      end
    endcase
    // sample the pins only when we are not the master
    cpu_addr_valid_nxt = !local_address_strobe_in_n && local_address_oe_n_r;
    cpu_addr_nxt = cpu_addr_r;
    if (cpu_addr_valid_nxt) begin
      cpu_addr_nxt = pin_addr;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= `LBM_ST_IDLE;
      cnt_r <= `LBM_CNT_ZERO;
      bus_request_out_n_r <= 1'b1;
      grant_acknowledge_out_n_r <= 1'b1;
      upper_local_address_out_r <= {`LBM_UPPER_W{1'b0}};
      lower_local_address_out_r <= {`LBM_LOWER_W{1'b0}};
      local_address_oe_n_r <= 1'b1;
      local_address_strobe_out_n_r <= 1'b1;
      local_address_strobe_oe_n_r <= 1'b1;
      bp_granted_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bus_request_out_n_r <= bus_request_out_n_nxt;
      grant_acknowledge_out_n_r <= grant_acknowledge_out_n_nxt;
      local_address_oe_n_r <= local_address_oe_n_nxt;
      local_address_strobe_oe_n_r <= local_address_strobe_oe_n_nxt;
      local_address_strobe_out_n_r <= local_address_strobe_out_n_nxt;
      bp_granted_r <= bp_granted_nxt;
      upper_local_address_out_r <= upper_local_address_out_nxt;
      lower_local_address_out_r <= lower_local_address_out_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // processor side address capture
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_addr_r <= {`LBM_ADDR_W{1'b0}};
      cpu_addr_valid_r <= 1'b0;
    end else begin
      cpu_addr_valid_r <= cpu_addr_valid_nxt;
      cpu_addr_r <= cpu_addr_nxt;
    end
  end

endmodule

//--- core/lbm_regs.vh
/*
 * Constants for the local bus mastership and error block: state codes,
 * address field layout and timing counts.
 * Assumes inclusion by bare name from the core/ design files.
 */
`ifndef LBM_REGS_VH
`define LBM_REGS_VH

// ----------------------------------------------------------------------
// address field layout
// ----------------------------------------------------------------------
`define LBM_UPPER_W 5
`define LBM_LOWER_W 2
`define LBM_ADDR_W 7

// ----------------------------------------------------------------------
// transfer mode codes
// ----------------------------------------------------------------------
`define LBM_TM_W 2
`define LBM_TM_OK 2'h0

// ----------------------------------------------------------------------
// master state machine
// ----------------------------------------------------------------------
`define LBM_ST_W 3
`define LBM_ST_IDLE 3'h0
`define LBM_ST_REQ 3'h1
`define LBM_ST_ADDR 3'h2
`define LBM_ST_STRB 3'h3
`define LBM_ST_DONE 3'h4

// ----------------------------------------------------------------------
// error sequencer states
// ----------------------------------------------------------------------
`define LBM_ES_W 2
`define LBM_ES_IDLE 2'h0
`define LBM_ES_ERR 2'h1
`define LBM_ES_RETRY 2'h2
`define LBM_ES_HOLD 2'h3

// ----------------------------------------------------------------------
// timing: address setup before strobe, error release delay
// ----------------------------------------------------------------------
`define LBM_SETUP_NS 8
`define LBM_CLK_NS 4
// setup time rounded up to whole clocks, sized for the counter
`define LBM_SETUP_CYC 2'h2
`define LBM_REL_CYC 2'h2
`define LBM_CNT_W 2
`define LBM_CNT_ZERO 2'h0
`define LBM_CNT_ONE 2'h1

`endif

//--- core/lbm_err_seq.v
/*
 * Error signalling sequencer: drives bus error and stop lines to the
 * processor for plain bus errors and for relinquish-and-retry.
 * Assumes synchronous inputs on one clock, asynchronous high reset.
 */
`timescale 1ns/1ns
`include "lbm_regs.vh"

module lbm_err_seq (
  input wire clk,
  input wire sys_rst,
  input wire cpu_access,
  input wire ack_cycle,
  input wire [`LBM_TM_W-1:0] transfer_mode_bits,
  input wire incoming_txn,
  input wire attention_null_cycle,
  input wire strobe_in_n,
  output reg bus_error_out_n_r,
  output reg processor_stop_line_n_r
);

  reg [`LBM_ES_W-1:0] st_r;
  reg [`LBM_ES_W-1:0] st_nxt;
  reg [`LBM_CNT_W-1:0] cnt_r;
  reg [`LBM_CNT_W-1:0] cnt_nxt;
  reg bus_error_out_n_nxt;
  reg processor_stop_line_n_nxt;
  reg null_seen_r;
  reg null_seen_nxt;

  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bus_error_out_n_nxt = bus_error_out_n_r;
    processor_stop_line_n_nxt = processor_stop_line_n_r;
    null_seen_nxt = null_seen_r | attention_null_cycle;
    case (st_r)
      `LBM_ES_IDLE: begin
        null_seen_nxt = 1'b0;
        if (cpu_access && incoming_txn) begin
          // incoming traffic wins; processor must back off
          st_nxt = `LBM_ES_RETRY;
          bus_error_out_n_nxt = 1'b0;
          processor_stop_line_n_nxt = 1'b0;
        end else if (cpu_access && ack_cycle && transfer_mode_bits != `LBM_TM_OK) begin
          st_nxt = `LBM_ES_ERR;
          bus_error_out_n_nxt = 1'b0;
        end
      end
      `LBM_ES_ERR: begin
        if (strobe_in_n) begin
          st_nxt = `LBM_ES_IDLE;
          bus_error_out_n_nxt = 1'b1;
        end
      end
      `LBM_ES_RETRY: begin
        if (strobe_in_n) begin
          st_nxt = `LBM_ES_HOLD;
          cnt_nxt = `LBM_REL_CYC;
        end
      end
      `LBM_ES_HOLD: begin
        // short delay after strobe release before dropping bus error
        if (cnt_r != `LBM_CNT_ZERO) begin
          cnt_nxt = cnt_r - `LBM_CNT_ONE;
        end else begin
          bus_error_out_n_nxt = 1'b1;
        end
        // stop held until null cycle; avoids backplane lockup
        if (null_seen_nxt && cnt_r == `LBM_CNT_ZERO) begin
          processor_stop_line_n_nxt = 1'b1;
          st_nxt = `LBM_ES_IDLE;
        end
      end
      default: begin
        st_nxt = `LBM_ES_IDLE;
        bus_error_out_n_nxt = 1'b1;
        processor_stop_line_n_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= `LBM_ES_IDLE;
      cnt_r <= `LBM_CNT_ZERO;
      null_seen_r <= 1'b0;
      bus_error_out_n_r <= 1'b1;
      processor_stop_line_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      null_seen_r <= null_seen_nxt;
      bus_error_out_n_r <= bus_error_out_n_nxt;
      processor_stop_line_n_r <= processor_stop_line_n_nxt;
    end
  end

endmodule

//--- test/lbm_assertions.sv
/* Port checker for lbm_top, bound onto every instance.
   Assumes lbm_regs.vh on the include path. */
`timescale 1ns/1ns
`include "lbm_regs.vh"
module lbm_chk (
  input wire clk,
  input wire sys_rst,
  input wire bp_req,
  input wire [`LBM_ADDR_W-1:0] bp_addr,
  input wire bp_access_done,
  input wire bus_grant_in_n,
  input wire bus_request_out_n_r,
  input wire grant_acknowledge_out_n_r,
  input wire local_address_oe_n_r,
  input wire [`LBM_UPPER_W-1:0] upper_local_address_out_r,
  input wire [`LBM_LOWER_W-1:0] lower_local_address_out_r,
  input wire local_address_strobe_in_n,
  input wire local_address_strobe_out_n_r,
  input wire bus_error_out_n_r,
  input wire processor_stop_line_n_r,
  input wire cpu_bp_access,
  input wire ack_cycle,
  input wire [`LBM_TM_W-1:0] transfer_mode_bits,
  input wire incoming_txn,
  input wire attention_null_cycle
);
  // ----
  // helpers
  // ----
  wire quiet = bus_error_out_n_r && processor_stop_line_n_r;
  reg null_seen_r;
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      null_seen_r <= 1'b0;
    else if (processor_stop_line_n_r)
      null_seen_r <= 1'b0;
    else if (attention_null_cycle)
      null_seen_r <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  req_cause_a: assert property ($fell(bus_request_out_n_r) |-> $past(bp_req))
    else $error("request without a requester");
  grant_wait_a: assert property ($fell(grant_acknowledge_out_n_r) |->
    $past(!bus_grant_in_n) && !local_address_oe_n_r) else $error("ack before grant");
  strobe_setup_a: assert property ($fell(local_address_strobe_out_n_r) |->
    $past(!local_address_oe_n_r, 2)) else $error("strobe before address");
  addr_map_a: assert property ($fell(local_address_oe_n_r) |->
    {upper_local_address_out_r, lower_local_address_out_r} == $past(bp_addr))
    else $error("driven address wrong");
  ack_release_a: assert property ($rose(grant_acknowledge_out_n_r) |->
    $past(bp_access_done) && bus_request_out_n_r) else $error("ack release wrong");
  bus_err_a: assert property (ack_cycle && |transfer_mode_bits && quiet &&
    cpu_bp_access && !incoming_txn |=> !bus_error_out_n_r) else $error("no bus error");
  retry_both_a: assert property (cpu_bp_access && incoming_txn && quiet |=>
    !bus_error_out_n_r && !processor_stop_line_n_r) else $error("no retry");
  stop_hold_a: assert property ($rose(processor_stop_line_n_r) |->
    null_seen_r || $past(attention_null_cycle)) else $error("stop released early");
  err_release_a: assert property ($rose(bus_error_out_n_r) |->
    $past(local_address_strobe_in_n)) else $error("error released under strobe");
  cover property ($fell(local_address_strobe_out_n_r));
  cover property (!bus_error_out_n_r && processor_stop_line_n_r);
  cover property (!processor_stop_line_n_r);
endmodule
bind lbm_top lbm_chk i_lbm_chk (.*);

//--- test/lbm_cpu_model.sv
/* Processor model: grants the local bus after a set delay.
   Assumes request from lbm_top, delay from the bench. */
`timescale 1ns/1ns
module lbm_cpu_model (
  input wire clk,
  input wire sys_rst,
  input wire bus_request_out_n_r,
  input wire [3:0] grant_dly,
  output reg bus_grant_in_n
);
  reg [3:0] cnt_r;
  // grant only ever answers a pending request
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_grant_in_n <= 1'b1;
      cnt_r <= 4'h0;
    end else if (bus_request_out_n_r) begin
      bus_grant_in_n <= 1'b1;
      cnt_r <= 4'h0;
    end else if (cnt_r >= grant_dly) begin
      bus_grant_in_n <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

//--- test/lbm_top_tb.sv
/* Bench for lbm_top with processor model and result queues.
   Assumes lbm_regs.vh on the include path. */
`timescale 1ns/1ns
`include "lbm_regs.vh"
module lbm_top_tb;
  reg clk, sys_rst, cpu_as_n, bp_req, done, cpu_acc, ackc, inc, nul;
  reg [`LBM_ADDR_W-1:0] bp_addr, cpu_a;
  reg [`LBM_TM_W-1:0] tm;
  reg [3:0] dly;
  reg [15:0] lf;
  reg so_d = 1'b1, be_d = 1'b1, cv_d = 1'b0;
  wire [`LBM_UPPER_W-1:0] uo;
  wire [`LBM_LOWER_W-1:0] lo;
  wire [`LBM_ADDR_W-1:0] ca;
  wire ao, so, s_oe, rq, gi, ga, be, st, gr, cv;
  // strobe pin taken from the processor when lbm_top does not drive it
  wire as_w = s_oe ? cpu_as_n : so;
  logic [6:0] exp_q[$];
  logic exp_e[$];
  integer failures = 0, check_count = 0, i;
  lbm_top i_lbm_top (.clk(clk), .sys_rst(sys_rst),
    .upper_local_address_in(ao ? cpu_a[6:2] : uo), .lower_local_address_in(ao ? cpu_a[1:0] : lo),
    .upper_local_address_out_r(uo), .lower_local_address_out_r(lo),
    .local_address_oe_n_r(ao), .local_address_strobe_in_n(as_w),
    .local_address_strobe_out_n_r(so), .local_address_strobe_oe_n_r(s_oe),
    .bus_request_out_n_r(rq), .bus_grant_in_n(gi), .grant_acknowledge_out_n_r(ga),
    .bus_error_out_n_r(be), .processor_stop_line_n_r(st), .bp_req(bp_req),
    .bp_addr(bp_addr), .bp_access_done(done), .bp_granted_r(gr), .cpu_bp_access(cpu_acc),
    .ack_cycle(ackc), .transfer_mode_bits(tm), .incoming_txn(inc),
    .attention_null_cycle(nul), .cpu_addr_r(ca), .cpu_addr_valid_r(cv));
  lbm_cpu_model i_lbm_cpu_model (.clk(clk), .sys_rst(sys_rst), .bus_request_out_n_r(rq),
    .grant_dly(dly), .bus_grant_in_n(gi));
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input [6:0] e, input [6:0] g);
    check_count = check_count + 1;
    if (e !== g) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // result watcher: mid-cycle, after edge updates land
  // ----
  always @(negedge clk) begin
    if (so === 1'b0 && so_d === 1'b1) begin
      chk("addr_out", exp_q.pop_front(), {uo, lo});
      chk("strobe_oe", 7'h00, {6'h00, s_oe});
    end
    if (cv === 1'b1 && cv_d === 1'b0)
      chk("cpu_addr", exp_q.pop_front(), ca);
    if (be === 1'b0 && be_d === 1'b1)
      chk("stop", exp_e.pop_front(), st);
    so_d = so;
    be_d = be;
    cv_d = cv;
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures = failures + 1;
    final_report;
  end
  initial begin
    {sys_rst, cpu_as_n} = 2'h3;
    {bp_req, done, cpu_acc, ackc, inc, nul} = 6'h00;
    bp_addr = 7'h00;
    cpu_a = 7'h00;
    tm = 2'h0;
    dly = 4'h0;
    lf = 16'hFFAF;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    // back-to-back masterships, random address and grant delay
    for (i = 0; i < 4; i = i + 1) begin
      lf = lfsr(lf);
      bp_addr = lf[6:0];
      dly = lf[10:7];
      exp_q.push_back(lf[6:0]);
      bp_req = 1'b1;
      wait (gr === 1'b1);
      step(1 + i);
      done = 1'b1;
      step(1);
      done = 1'b0;
      bp_req = 1'b0;
      step(1);
    end
    $display("test mastership done");
    lf = lfsr(lf);
    cpu_a = lf[6:0];
    cpu_acc = 1'b1;
    // plain completion and every error code
    for (i = 0; i < 4; i = i + 1) begin
      exp_q.push_back(cpu_a);
      if (i != 0)
        exp_e.push_back(1'b1);
      step(1);
      cpu_as_n = 1'b0;
      tm = i;
      ackc = 1'b1;
      step(1);
      ackc = 1'b0;
      step(2);
      cpu_as_n = 1'b1;
      wait (be === 1'b1);
      step(2);
    end
    // error code with no processor access pending raises nothing
    cpu_acc = 1'b0;
    ackc = 1'b1;
    tm = 2'h1;
    step(1);
    ackc = 1'b0;
    step(1);
    chk("no_bus_error", 7'h01, {6'h00, be});
    cpu_acc = 1'b1;
    $display("test bus error done");
    exp_q.push_back(cpu_a);
    exp_e.push_back(1'b0);
    cpu_as_n = 1'b0;
    step(1);
    inc = 1'b1;
    ackc = 1'b1;
    tm = 2'h3;
    step(1);
    inc = 1'b0;
    ackc = 1'b0;
    step(2);
    cpu_as_n = 1'b1;
    step(6);
    chk("stop_held", 7'h00, {6'h00, st});
    nul = 1'b1;
    step(1);
    nul = 1'b0;
    wait (st === 1'b1);
    step(2);
    $display("test retry done");
    final_report;
  end
endmodule
